/* File: dhm_pkg.sv */
// package: constants and types for the drive health monitor
`default_nettype none
package dhm_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    // times in their own units
    localparam int unsigned SCHED_HOURS = 2;
    localparam int unsigned TEMP_MINUTES = 10;
    localparam int unsigned DELAY_ONLINE_MS = 42;
    localparam int unsigned DELAY_FULL_MS = 163;
    // derived cycle counts (64 bit to hold hours at 100 MHz)
    localparam longint unsigned SCHED_CYCLES = longint'(SCHED_HOURS) * 3600 * CLK_HZ;
    localparam longint unsigned TEMP_CYCLES = longint'(TEMP_MINUTES) * 60 * CLK_HZ;
    localparam longint unsigned DELAY_ONLINE_CYCLES = longint'(DELAY_ONLINE_MS) * (CLK_HZ / 1000);
    localparam longint unsigned DELAY_FULL_CYCLES = longint'(DELAY_FULL_MS) * (CLK_HZ / 1000);
    // edges after reset before the synchronised sensor value can be trusted
    localparam logic [2:0] TEMP_BOOT_WAIT = 3'h4;
    // mode page, log pages and parameter codes
    localparam logic [7:0] IEC_PAGE = 8'h1c;
    localparam logic [7:0] SCHED_LOG_PAGE = 8'h3e;
    localparam logic [7:0] TEMP_LOG_PAGE = 8'h0d;
    localparam logic [15:0] TEMP_PRIMARY_CODE = 16'h0000;
    localparam logic [15:0] TEMP_REF_CODE = 16'h0001;
    // temperatures in degrees C
    localparam logic [7:0] TEMP_TRIP_FIXED = 8'h44;
    localparam logic [7:0] TEMP_REF_RESET = 8'h44;
    // sense codes: key, asc, ascq
    localparam logic [7:0] SENSE_KEY_RECOVERED = 8'h01;
    localparam logic [7:0] ASC_PREDICT = 8'h5d;
    localparam logic [7:0] ASC_WARN = 8'h0b;
    localparam logic [7:0] ASCQ_TEMP = 8'h01;
    localparam logic [7:0] ASC_ROUNDED = 8'h37;
    localparam logic [7:0] ASCQ_NONE = 8'h00;
    localparam logic [3:0] REPORT_METHOD_NONE = 4'h0;

    typedef enum logic [1:0] {
        DHM_IDLE = 2'b00,
        DHM_MEASURE = 2'b01,
        DHM_SAVE = 2'b10
    } dhm_off_state_t;
endpackage
`default_nettype wire

/* File: dhm_attr_if.sv */
// interface: per-attribute event and judgement signals
`timescale 1ns/1ps
`default_nettype none
interface dhm_attr_if #(parameter int N = 4);
    logic [N-1:0] op;
    logic [N-1:0] err;
    logic [N-1:0] enable;
    logic [N-1:0] predict;
    modport monitor (input op, input err, input enable, output predict);
    modport owner (output op, output err, output enable, input predict);
endinterface
`default_nettype wire

/* File: dhm_attr_rate.sv */
// one attribute: interval, failure and failure history counters
`timescale 1ns/1ps
`default_nettype none
module dhm_attr_rate #(
    parameter int IDX = 0,
    parameter int N = 4,
    parameter int CW = 16,
    parameter logic [CW-1:0] INTERVAL = 16'h0100,
    parameter logic [CW-1:0] ERR_THRESH = 16'h0008,
    parameter logic [7:0] HIST_THRESH = 8'h04
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // attribute events
    dhm_attr_if.monitor attr
);
    logic [CW-1:0] interval_cnt;
    logic [CW-1:0] fail_cnt;
    logic [7:0] hist_cnt;
    logic bad_flag;
    logic interval_end;

    assign interval_end = attr.enable[IDX] && attr.op[IDX] && (interval_cnt == INTERVAL - CW'(1));

    // --------------------------------
    // rate counters
    // --------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interval_cnt <= '0;
            fail_cnt <= '0;
            bad_flag <= 1'b0;
        end else if (interval_end) begin
            interval_cnt <= '0;
            fail_cnt <= '0;
            bad_flag <= 1'b0;
        end else if (attr.enable[IDX]) begin
            if (attr.op[IDX]) begin
                interval_cnt <= interval_cnt + CW'(1);
            end
            if (attr.err[IDX] && fail_cnt != '1) begin
                fail_cnt <= fail_cnt + CW'(1);
            end
            if (fail_cnt > ERR_THRESH) begin
                bad_flag <= 1'b1; // exceeded before interval expiry
            end
        end
    end

    // --------------------------------
    // failure history
    // --------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hist_cnt <= '0;
        end else if (interval_end) begin
            if (bad_flag || fail_cnt > ERR_THRESH) begin
                if (hist_cnt != 8'hff) begin
                    hist_cnt <= hist_cnt + 8'h01;
                end
            end else if (hist_cnt != 8'h00) begin
                hist_cnt <= hist_cnt - 8'h01;
            end
        end
    end

    assign attr.predict[IDX] = (hist_cnt >= HIST_THRESH);

    AST_HIST_FLOOR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        interval_end && hist_cnt == 8'h00 && !bad_flag && fail_cnt <= ERR_THRESH |=> hist_cnt == 8'h00)
        else $error("history counter wrapped below zero");
    AST_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        interval_end |=> (interval_cnt == '0 && fail_cnt == '0))
        else $error("counters not cleared at interval end");
endmodule
`default_nettype wire

/* File: dhm_thermal.sv */
// thermal monitor: periodic sample and two trip points
`timescale 1ns/1ps
`default_nettype none
module dhm_thermal
    import dhm_pkg::*;
#(
    parameter longint unsigned TEMP_CYC = dhm_pkg::TEMP_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // sensor and reference
    input wire logic [7:0] temp_sync_i,
    input wire logic [7:0] ref_temp_i,
    // results
    output logic [7:0] temp_o,
    output logic sample_o,
    output logic over_fixed_o,
    output logic over_ref_o
);
    logic [39:0] tick;
    logic [2:0] boot_cnt;

    // --------------------------------
    // sample schedule
    // --------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick <= '0;
            boot_cnt <= '0;
            sample_o <= 1'b0;
        end else begin
            sample_o <= 1'b0;
            if (boot_cnt != TEMP_BOOT_WAIT) begin
                // wait for the sensor to cross the synchroniser, else the first sample reads zero
                boot_cnt <= boot_cnt + 3'h1;
                sample_o <= boot_cnt == TEMP_BOOT_WAIT - 3'h1; // power-up sample
            end else if (tick == 40'(TEMP_CYC - 1)) begin
                tick <= '0;
                sample_o <= 1'b1;
            end else begin
                tick <= tick + 40'd1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            temp_o <= '0;
            over_fixed_o <= 1'b0;
            over_ref_o <= 1'b0;
        end else if (sample_o) begin
            temp_o <= temp_sync_i;
            over_fixed_o <= temp_sync_i > TEMP_TRIP_FIXED;
            over_ref_o <= temp_sync_i > ref_temp_i;
        end
    end

    AST_TRIP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sample_o && (temp_sync_i > TEMP_TRIP_FIXED) |=> over_fixed_o)
        else $error("fixed trip point missed");
endmodule
`default_nettype wire

/* File: dhm_top.sv */
// top: drive health monitor with scheduling, reporting and thermal warnings
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - exception disable suspends all prediction functions except the 01-5Dxx report of a stored failure
// - collect on-line data during normal operations
// - online-only select skips off-line measurement
// - rezero forces measurement, restarts two-hour timer
// - log sense returns time to next pass
// - scheduled pass every two hours, when idle
// - measurement and save run uninterrupted
// - delay bounded: 42 ms online, 163 full
// - predictive failure reported as 01-5Dxx
// - reported failure kept across resets, power
// - per attribute interval and failure counters
// - judge interval, then clear both counters
// - history counter up/down, floored at zero
// - history at threshold signals predictive failure
// - sample temperature at power-up, every ten minutes
// - temperature over trip raises 01-0B01
// - temperature in unit code and log
// - warning enable gates; method selects delivery
// - two trip points, first fixed 68C
// - host sets reference trip, default 68C
// - reference above 68C clamped, rounding reported
// - threatening temperature stores prediction frame
module dhm_top
    import dhm_pkg::*;
#(
    parameter int N_ATTR = 4,
    parameter longint unsigned SCHED_CYC = dhm_pkg::SCHED_CYCLES,
    parameter longint unsigned TEMP_CYC = dhm_pkg::TEMP_CYCLES,
    parameter longint unsigned MEAS_CYC = dhm_pkg::DELAY_FULL_CYCLES,
    parameter logic [N_ATTR*16-1:0] INTERVALS = {N_ATTR{16'h0100}},
    parameter logic [N_ATTR*16-1:0] ERR_THRESHS = {N_ATTR{16'h0008}},
    parameter logic [N_ATTR*8-1:0] HIST_THRESHS = {N_ATTR{8'h04}}
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // informational exceptions control page fields
    input wire logic exception_disable_i,
    input wire logic online_only_i,
    input wire logic temp_warning_enable_i,
    input wire logic [3:0] report_method_i,
    // host commands
    input wire logic rezero_i,
    input wire logic log_sense_sched_i,
    input wire logic ref_temp_wr_i,
    input wire logic [7:0] ref_temp_wdata_i,
    input wire logic loop_idle_i,
    // drive activity per attribute
    input wire logic [N_ATTR-1:0] attr_op_i,
    input wire logic [N_ATTR-1:0] attr_err_i,
    // saved predictive failure from non-volatile store
    input wire logic nv_predict_i,
    // save engine handshake
    input wire logic save_done_i,
    // temperature sensor, asynchronous
    input wire logic [7:0] temp_raw_i,
    // answers and status
    output logic [39:0] sched_remain_o,
    output logic sched_remain_valid_o,
    output logic online_collect_o,
    output logic measure_busy_o,
    output logic save_req_o,
    output logic nv_predict_o,
    output logic predict_fail_o,
    output logic sense_valid_o,
    output logic [7:0] sense_key_o,
    output logic [7:0] sense_asc_o,
    output logic [7:0] sense_ascq_o,
    output logic [7:0] sense_fru_o,
    output logic [7:0] temp_log_primary_o,
    output logic [7:0] temp_log_ref_o,
    output logic frame_save_o
);
    import dhm_pkg::*;

    // ------------------------------------------------
    // temperature synchroniser (3 flops, 2nd==3rd)
    // ------------------------------------------------
    logic [7:0] t_s1, t_s2, t_s3, t_stable;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            t_s1 <= '0;
            t_s2 <= '0;
            t_s3 <= '0;
            t_stable <= '0;
        end else begin
            t_s1 <= temp_raw_i;
            t_s2 <= t_s1;
            t_s3 <= t_s2;
            if (t_s2 == t_s3) begin
                t_stable <= t_s3;
            end
        end
    end

    // ------------------------------------------------
    // attribute monitors
    // ------------------------------------------------
    logic enabled;
    assign enabled = !exception_disable_i;

    dhm_attr_if #(.N(N_ATTR)) attr_bus ();
    assign attr_bus.op = attr_op_i;
    assign attr_bus.err = attr_err_i;
    assign attr_bus.enable = {N_ATTR{enabled}};

    for (genvar g = 0; g < N_ATTR; g++) begin : g_attr
        dhm_attr_rate #(
            .IDX(g),
            .N(N_ATTR),
            .CW(16),
            .INTERVAL(INTERVALS[g*16 +: 16]),
            .ERR_THRESH(ERR_THRESHS[g*16 +: 16]),
            .HIST_THRESH(HIST_THRESHS[g*8 +: 8])
        ) u_attr (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .attr(attr_bus.monitor)
        );
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            online_collect_o <= 1'b0;
        end else begin
            online_collect_o <= enabled;
        end
    end

    // ------------------------------------------------
    // off-line schedule and measurement
    // ------------------------------------------------
    dhm_off_state_t off_state;
    logic [39:0] sched_cnt;
    logic [39:0] meas_cnt;
    logic sched_due;
    logic offline_ok;
    assign offline_ok = enabled && !online_only_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sched_cnt <= 40'(SCHED_CYC);
            sched_due <= 1'b0;
        end else if (rezero_i && offline_ok) begin
            sched_cnt <= 40'(SCHED_CYC);
            sched_due <= 1'b0;
        end else if (off_state == DHM_IDLE && sched_due && loop_idle_i) begin
            sched_cnt <= 40'(SCHED_CYC);
            sched_due <= 1'b0;
        end else if (sched_cnt != '0) begin
            sched_cnt <= sched_cnt - 40'd1;
        end else begin
            sched_due <= offline_ok;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            off_state <= DHM_IDLE;
            meas_cnt <= '0;
        end else begin
            unique case (off_state)
                DHM_IDLE: begin
                    if (offline_ok && (rezero_i || (sched_due && loop_idle_i))) begin
                        off_state <= DHM_MEASURE;
                        meas_cnt <= 40'(MEAS_CYC - 1);
                    end
                end
                DHM_MEASURE: begin
                    // no abort path: a pass runs to completion
                    if (meas_cnt == '0) begin
                        off_state <= DHM_SAVE;
                    end else begin
                        meas_cnt <= meas_cnt - 40'd1;
                    end
                end
                DHM_SAVE: begin
                    if (save_done_i) begin
                        off_state <= DHM_IDLE;
                    end
                end
                default: off_state <= DHM_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            measure_busy_o <= 1'b0;
            save_req_o <= 1'b0;
            sched_remain_o <= '0;
            sched_remain_valid_o <= 1'b0;
        end else begin
            measure_busy_o <= off_state != DHM_IDLE;
            save_req_o <= off_state == DHM_SAVE && !save_done_i;
            sched_remain_valid_o <= log_sense_sched_i;
            if (log_sense_sched_i) begin
                sched_remain_o <= sched_cnt;
            end
        end
    end

    // ------------------------------------------------
    // predictive failure, sticky via non-volatile copy
    // ------------------------------------------------
    logic any_predict;
    logic nv_loaded;
    assign any_predict = |attr_bus.predict;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            predict_fail_o <= 1'b0;
            nv_predict_o <= 1'b0;
            nv_loaded <= 1'b0;
        end else begin
            nv_loaded <= 1'b1;
            if (!nv_loaded) begin
                predict_fail_o <= nv_predict_i; // restored after power cycle
                nv_predict_o <= nv_predict_i;
            end else if (enabled && any_predict) begin
                predict_fail_o <= 1'b1;
                nv_predict_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------
    // thermal monitor and reference trip point
    // ------------------------------------------------
    logic [7:0] temp_now;
    logic temp_sample, over_fixed, over_ref;
    logic round_evt;

    dhm_thermal #(.TEMP_CYC(TEMP_CYC)) u_thermal (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .temp_sync_i(t_stable),
        .ref_temp_i(temp_log_ref_o),
        .temp_o(temp_now),
        .sample_o(temp_sample),
        .over_fixed_o(over_fixed),
        .over_ref_o(over_ref)
    );

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            temp_log_ref_o <= TEMP_REF_RESET;
            round_evt <= 1'b0;
        end else begin
            round_evt <= 1'b0;
            if (ref_temp_wr_i) begin
                if (ref_temp_wdata_i > TEMP_TRIP_FIXED) begin
                    temp_log_ref_o <= TEMP_TRIP_FIXED;
                    round_evt <= 1'b1;
                end else begin
                    temp_log_ref_o <= ref_temp_wdata_i;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            temp_log_primary_o <= '0;
            frame_save_o <= 1'b0;
        end else begin
            temp_log_primary_o <= temp_now;
            frame_save_o <= temp_sample && (t_stable > TEMP_TRIP_FIXED) && enabled;
        end
    end

    // ------------------------------------------------
    // sense data; rounding and temperature beat prediction
    // ------------------------------------------------
    logic warn_now;
    assign warn_now = temp_warning_enable_i && enabled && (over_fixed || over_ref)
        && report_method_i != REPORT_METHOD_NONE;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sense_valid_o <= 1'b0;
            sense_key_o <= '0;
            sense_asc_o <= '0;
            sense_ascq_o <= '0;
            sense_fru_o <= '0;
        end else begin
            sense_fru_o <= temp_now;
            sense_key_o <= SENSE_KEY_RECOVERED;
            if (round_evt) begin
                sense_valid_o <= 1'b1;
                sense_asc_o <= ASC_ROUNDED;
                sense_ascq_o <= ASCQ_NONE;
            end else if (warn_now) begin
                sense_valid_o <= 1'b1;
                sense_asc_o <= ASC_WARN;
                sense_ascq_o <= ASCQ_TEMP;
            end else if (predict_fail_o && report_method_i != REPORT_METHOD_NONE) begin
                sense_valid_o <= 1'b1;
                sense_asc_o <= ASC_PREDICT;
                sense_ascq_o <= ASCQ_NONE;
            end else begin
                sense_valid_o <= 1'b0;
                sense_asc_o <= '0;
                sense_ascq_o <= '0;
            end
        end
    end

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    sequence s_start;
        off_state == DHM_IDLE && offline_ok && rezero_i;
    endsequence
    AST_REZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_start |=> off_state == DHM_MEASURE && sched_cnt == 40'(SCHED_CYC))
        else $error("rezero did not start pass");
    AST_NO_ABORT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        off_state == DHM_MEASURE |=> off_state != DHM_IDLE)
        else $error("measurement aborted");
    AST_ONLINE_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(off_state) == DHM_IDLE && !$past(offline_ok) |-> off_state == DHM_IDLE)
        else $error("off-line pass in online-only mode");
    AST_PREDICT_STICKY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        nv_loaded && predict_fail_o |=> predict_fail_o)
        else $error("predictive failure lost");
    AST_CLAMP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ref_temp_wr_i && ref_temp_wdata_i > TEMP_TRIP_FIXED |=> temp_log_ref_o == TEMP_TRIP_FIXED ##1 sense_valid_o)
        else $error("reference not clamped");
    AST_SUSPEND: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        exception_disable_i && nv_loaded |=> predict_fail_o == $past(predict_fail_o))
        else $error("prediction active while disabled");
endmodule
`default_nettype wire

/* File: dhm_host_model.sv */
// partner model: loop idle source and disc save engine
`timescale 1ns/1ps
`default_nettype none
module dhm_host_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // bench control
    input wire logic loop_busy_i,
    input wire logic slow_i,
    // device side
    input wire logic save_req_i,
    output logic loop_idle_o,
    output logic save_done_o
);
    logic [3:0] cnt;
    logic served;
    assign loop_idle_o = !loop_busy_i;
    // one done pulse per request; slow mode stands for a long disc write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 4'h0;
            served <= 1'b0;
            save_done_o <= 1'b0;
        end else if (!save_req_i) begin
            cnt <= 4'h0;
            served <= 1'b0;
            save_done_o <= 1'b0;
        end else if (!served && cnt == (slow_i ? 4'hc : 4'h2)) begin
            served <= 1'b1;
            save_done_o <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
            save_done_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: tb.sv */
// testbench: drive health monitor against the host model
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dhm_pkg::*;
    localparam int SCH = 200;
    localparam int TMP = 50;
    logic clk_i, rst_n_i, exception_disable_i, online_only_i, temp_warning_enable_i, pf;
    logic rezero_i, log_sense_sched_i, ref_temp_wr_i, loop_idle_i, nv_predict_i, save_done_i;
    logic loop_busy, slow, sched_remain_valid_o, online_collect_o, measure_busy_o, save_req_o;
    logic nv_predict_o, predict_fail_o, sense_valid_o, frame_save_o;
    logic [3:0] report_method_i, attr_op_i, attr_err_i;
    logic [7:0] ref_temp_wdata_i, temp_raw_i, t0, sense_key_o, sense_asc_o, sense_ascq_o;
    logic [7:0] sense_fru_o, temp_log_primary_o, temp_log_ref_o;
    logic [39:0] sched_remain_o, r1;
    int n_mismatch, n_checks, cyc, i, k, idx, hist;
    int pat[6] = '{0, 1, 0, 1, 1, 0};

    dhm_top #(.SCHED_CYC(SCH), .TEMP_CYC(TMP), .MEAS_CYC(10), .INTERVALS({4{16'h0004}}),
        .ERR_THRESHS({4{16'h0001}}), .HIST_THRESHS({4{8'h02}})) i_dhm_top (
        .clk_i, .rst_n_i, .exception_disable_i, .online_only_i, .temp_warning_enable_i, .report_method_i,
        .rezero_i, .log_sense_sched_i, .ref_temp_wr_i, .ref_temp_wdata_i, .loop_idle_i, .attr_op_i,
        .attr_err_i, .nv_predict_i, .save_done_i, .temp_raw_i, .sched_remain_o, .sched_remain_valid_o,
        .online_collect_o, .measure_busy_o, .save_req_o, .nv_predict_o, .predict_fail_o, .sense_valid_o,
        .sense_key_o, .sense_asc_o, .sense_ascq_o, .sense_fru_o, .temp_log_primary_o, .temp_log_ref_o,
        .frame_save_o);
    dhm_host_model i_dhm_host_model (.clk_i, .rst_n_i, .loop_busy_i(loop_busy), .slow_i(slow),
        .save_req_i(save_req_o), .loop_idle_o(loop_idle_i), .save_done_o(save_done_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    function automatic logic [7:0] exp_ref(logic [7:0] v);
        return (v > TEMP_TRIP_FIXED) ? TEMP_TRIP_FIXED : v;
    endfunction
    function automatic int next_hist(int h, int nerr);
        return (nerr > 1) ? h + 1 : ((h > 0) ? h - 1 : 0);
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(logic [39:0] seen, logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic rezero();
        rezero_i = 1'b1;
        tick(1);
        rezero_i = 1'b0;
        tick(2);
    endtask
    task automatic wr_ref(logic [7:0] v);
        ref_temp_wdata_i = v;
        ref_temp_wr_i = 1'b1;
        tick(1);
        ref_temp_wr_i = 1'b0;
        tick(1);
        chk(temp_log_ref_o, exp_ref(v));
    endtask
    task automatic run_interval(int a, int nerr);
        for (int j = 0; j < nerr + 4; j++) begin
            if (j < nerr) begin
                attr_err_i[a] = 1'b1;
            end else begin
                attr_op_i[a] = 1'b1;
            end
            tick(1);
            attr_err_i[a] = 1'b0;
            attr_op_i[a] = 1'b0;
            tick(1);
        end
        tick(3);
    endtask

    initial begin
        {exception_disable_i, online_only_i, rezero_i, log_sense_sched_i, ref_temp_wr_i, slow} = '0;
        {nv_predict_i, attr_op_i, attr_err_i, ref_temp_wdata_i} = '0;
        {temp_warning_enable_i, loop_busy} = 2'b11;
        void'($urandom(32'hebfc51b1));
        report_method_i = 4'($urandom_range(15, 1));
        t0 = 8'($urandom_range(64, 32));
        temp_raw_i = t0;
        rst_n_i = 1'b0;
        tick(12);
        rst_n_i = 1'b1;
        tick(6);
        chk(temp_log_ref_o, TEMP_REF_RESET);
        chk({temp_log_primary_o, sense_fru_o}, {t0, t0});
        chk(predict_fail_o, 1'b0);
        for (k = 0; k < 2; k++) begin
            exception_disable_i = (k == 0);
            online_only_i = (k == 1);
            rezero();
            tick(2);
            chk(measure_busy_o, 1'b0);
            chk(online_collect_o, k == 1);
        end
        {exception_disable_i, online_only_i} = 2'b00;
        tick(80);
        rezero();
        chk(measure_busy_o, 1'b1);
        for (i = 0; i < 20 && !save_req_o; i++) tick(1);
        chk(i <= 12 && save_req_o, 1'b1);
        for (i = 0; i < 20 && measure_busy_o; i++) tick(1);
        chk(measure_busy_o, 1'b0);
        log_sense_sched_i = 1'b1;
        tick(1);
        log_sense_sched_i = 1'b0;
        r1 = sched_remain_o;
        chk(sched_remain_valid_o, 1'b1);
        chk(r1 > SCH - 40 && r1 <= SCH, 1'b1);
        tick(1);
        chk(sched_remain_valid_o, 1'b0);
        chk(sched_remain_o, r1);
        log_sense_sched_i = 1'b1;
        tick(1);
        log_sense_sched_i = 1'b0;
        chk(sched_remain_o, r1 - 40'h2);
        wr_ref(8'($urandom_range(68, 0)));
        wr_ref(8'h50);
        chk({sense_valid_o, sense_asc_o, sense_ascq_o}, {1'b1, ASC_ROUNDED, ASCQ_NONE});
        idx = $urandom_range(3, 0);
        hist = 0;
        pf = 1'b0;
        for (k = 0; k < 6; k++) begin
            i = pat[k] ? 2 + $urandom_range(1, 0) : $urandom_range(1, 0);
            run_interval(idx, i);
            hist = next_hist(hist, i);
            pf = pf | (hist >= 2);
            chk(predict_fail_o, pf);
        end
        chk({sense_valid_o, sense_key_o, sense_asc_o}, {1'b1, SENSE_KEY_RECOVERED, ASC_PREDICT});
        chk(nv_predict_o, 1'b1);
        wr_ref(t0 - 8'h01);
        for (i = 0; i < TMP + 10 && sense_asc_o !== ASC_WARN; i++) tick(1);
        chk({sense_asc_o, sense_ascq_o, sense_fru_o}, {ASC_WARN, ASCQ_TEMP, t0});
        temp_warning_enable_i = 1'b0;
        tick(3);
        chk(sense_asc_o, ASC_PREDICT);
        report_method_i = REPORT_METHOD_NONE;
        tick(2);
        chk(sense_valid_o, 1'b0);
        report_method_i = 4'($urandom_range(15, 1));
        temp_raw_i = 8'h50;
        for (i = 0; i < TMP + 10 && !frame_save_o; i++) tick(1);
        chk(frame_save_o, 1'b1);
        nv_predict_i = 1'b1;
        rst_n_i = 1'b0;
        tick(2);
        rst_n_i = 1'b1;
        tick(2);
        chk(predict_fail_o, 1'b1);
        slow = 1'b1;
        tick(SCH + 10);
        chk(measure_busy_o, 1'b0);
        loop_busy = 1'b0;
        for (i = 0; i < 5 && !measure_busy_o; i++) tick(1);
        chk(measure_busy_o, 1'b1);
        loop_busy = 1'b1;
        for (i = 0; i < 20 && !save_req_o; i++) tick(1);
        chk({measure_busy_o, save_req_o}, 2'b11);
        for (i = 0; i < 30 && measure_busy_o; i++) tick(1);
        chk(measure_busy_o, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
